/* verilog/nco_pkg.sv */
// nco_pkg: constants, register map and carrier types of the oscillator.
// assumes one 125 MHz clock and a 32-bit AXI4-Lite register bus.
package nco_pkg;

    // clock and default tuning
    localparam int      CLK_PERIOD_NS = 8;
    localparam longint  CLK_HZ        = 1000000000 / CLK_PERIOD_NS;
    localparam longint  F_OUT_HZ      = 1000000;

    // widths of this build
    localparam int ACC_W   = 32;
    localparam int ANGLE_W = 16;
    localparam int MAG_W   = 16;
    localparam int FM_W    = 32;
    localparam int PM_W    = 16;
    localparam int HOP_N   = 16;
    localparam int HOP_AW  = 4;

    // legal ranges of the build widths
    localparam int ACC_W_MIN      = 4;
    localparam int ACC_W_MAX      = 64;
    localparam int ANGLE_W_MIN    = 4;
    localparam int ANGLE_W_MAX_LUT = 24;
    localparam int ANGLE_W_MAX_ROT = 32;
    localparam int MAG_W_MIN      = 10;
    localparam int MAG_W_MAX      = 32;
    localparam int FM_W_MIN       = 4;
    localparam int FM_W_MAX       = 64;
    localparam int PM_W_MIN       = 4;
    localparam int PM_W_MAX       = 32;
    localparam bit ALGO_IS_LUT    = 1'b0;

    // default increment and the frequency that it really gives
    localparam logic [ACC_W-1:0] DEF_INC =
        ACC_W'((F_OUT_HZ << ACC_W) / CLK_HZ);
    localparam longint REAL_F_OUT_HZ = (longint'(DEF_INC) * CLK_HZ) >> ACC_W;

    // pipeline
    localparam int BASE_LAT    = 4;
    localparam int DITH_LAT_ON = 2;
    localparam int DITH_LAT_OFF = 0;
    localparam int FILL_W      = 4;
    localparam int DITH_LVL_W  = 3;
    localparam int DITH_LVL_MAX = 7;
    localparam int LFSR_W      = 16;
    localparam logic [LFSR_W-1:0] LFSR_SEED = 16'hACE1;
    localparam logic [LFSR_W-1:0] LFSR_TAPS = 16'hB400;
    localparam logic [ANGLE_W-1:0] QUARTER_TURN = 16'h4000;
    localparam int SINE_SHIFT  = 2 * ANGLE_W - 4 - (MAG_W - 1);
    localparam logic signed [2*ANGLE_W+1:0] SAT_POS = 34'sh0_7FFF;
    localparam logic signed [ANGLE_W:0]     HALF_TURN = 17'sh0_8000;

    // register map (byte addresses)
    localparam int ADDR_W = 8;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 8'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 8'h04;
    localparam logic [ADDR_W-1:0] REG_COUNT  = 8'h08;
    localparam logic [ADDR_W-1:0] REG_FREQ   = 8'h0C;
    localparam logic [1:0]        HOP_PAGE   = 2'h1;

    // control and status fields
    localparam int CTRL_HOP_ON_BIT  = 0;
    localparam int CTRL_HOP_SEL_LSB = 4;
    localparam int CTRL_DITH_LSB    = 8;
    localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
    localparam logic [31:0] CTRL_MASK = 32'h0000_07F1;
    localparam int STAT_CFG_OK_BIT  = 0;
    localparam int STAT_RUN_BIT     = 1;
    localparam int STAT_HOP_BIT     = 2;
    localparam int STAT_FIFO_LSB    = 4;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [PM_W-1:0]  phase_mod;
        logic [FM_W-1:0]  freq_mod;
        logic [ACC_W-1:0] phase_inc;
    } nco_in_t;

    typedef struct packed {
        logic [MAG_W-1:0] cos_v;
        logic [MAG_W-1:0] sin_v;
    } nco_smp_t;

endpackage : nco_pkg

/* verilog/nco_in_fifo.sv */
// nco_in_fifo: small valid/ready buffer in front of the accumulator.
// assumes a single clock; ready and valid come straight from flip-flops.
`timescale 1ns/1ps
module nco_in_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic [$clog2(DEPTH+1)-1:0] level
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic             push;
    logic             pop;
    logic [CW-1:0]    next_level;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + PW'(1));
    endfunction : ptr_inc

    assign push       = in_valid & in_ready;
    assign pop        = out_valid & out_ready;
    assign next_level = CW'(level + CW'(push) - CW'(pop));
    assign out_data   = mem[rd_ptr];

    always_ff @(posedge aclk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_ptr    <= '0;
            rd_ptr    <= '0;
            level     <= '0;
            in_ready  <= 1'b0;
            out_valid <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr <= ptr_inc(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= ptr_inc(rd_ptr);
            end
            level     <= next_level;
            in_ready  <= (next_level != CW'(DEPTH));
            out_valid <= (next_level != '0);
        end
    end
endmodule : nco_in_fifo

/* verilog/nco_core.sv */
// nco_core: phase accumulator oscillator with hopping table, modulation and dither.
// assumes an AXI4-Lite master for the registers and a sample sink that never stalls.
//
// How it works
// R1: accumulator width is a build value from 4 to 64, not below angle width.
// R2: angle width starts at 4; at most 24 for tables, 32 otherwise.
// R3: sine and cosine sample width is a build value from 10 to 32.
// R4: dither is optional at build; its level is set from minimum to maximum.
// R5: default increment comes from clock rate and wanted output frequency.
// R6: frequency modulation input used only if built in; width 4 to 64.
// R7: frequency modulation path has one or two register stages.
// R8: phase modulation input used only if built in; width 4 to 32.
// R9: phase modulation path has one or two register stages.
// R10: samples go out as a stream; ready from the sink is ignored.
// R11: inputs arrive on a stream sink, samples leave on a separate source.
// R12: with hopping built in, software writes the hop increments at run time.
// R13: the register address selects one of sixteen hop increments.
// R14: samples only while clock enable is high, after a fixed start latency.
// R15: a hop select chooses which stored increment drives the accumulator.
// R16: a write strobe stores a value into the addressed hop register.
// R17: dither adds two cycles of latency, none when left out.
// R18: accumulator adds increment plus modulation; top bits plus phase offset feed the generator.
`timescale 1ns/1ps
module nco_core #(
    parameter bit DITHER_EN = 1'b1,
    parameter bit FM_EN     = 1'b1,
    parameter int FM_PIPE   = 1,
    parameter bit PM_EN     = 1'b1,
    parameter int PM_PIPE   = 1,
    parameter bit HOP_EN    = 1'b1
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic                       clken,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [nco_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    output logic [1:0]                      s_axi_bresp,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    input  wire logic [nco_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    input  wire logic                       s_valid,
    output logic                            s_ready,
    input  wire nco_pkg::nco_in_t           s_data,
    output logic                            m_valid,
    input  wire logic                       m_ready,
    output nco_pkg::nco_smp_t               m_data
);
    localparam int DITH_LAT = DITHER_EN ? nco_pkg::DITH_LAT_ON : nco_pkg::DITH_LAT_OFF;
    localparam int LAT      = nco_pkg::BASE_LAT + DITH_LAT;
    localparam int ANG_MAX  = nco_pkg::ALGO_IS_LUT ? nco_pkg::ANGLE_W_MAX_LUT
                                                   : nco_pkg::ANGLE_W_MAX_ROT;
    localparam bit CFG_OK =
        (nco_pkg::ACC_W >= nco_pkg::ACC_W_MIN) && (nco_pkg::ACC_W <= nco_pkg::ACC_W_MAX) &&
        (nco_pkg::ACC_W >= nco_pkg::ANGLE_W) &&
        (nco_pkg::ANGLE_W >= nco_pkg::ANGLE_W_MIN) && (nco_pkg::ANGLE_W <= ANG_MAX) &&
        (nco_pkg::MAG_W >= nco_pkg::MAG_W_MIN) && (nco_pkg::MAG_W <= nco_pkg::MAG_W_MAX) &&
        (nco_pkg::FM_W >= nco_pkg::FM_W_MIN) && (nco_pkg::FM_W <= nco_pkg::FM_W_MAX) &&
        (nco_pkg::FM_W <= nco_pkg::ACC_W) &&
        (nco_pkg::PM_W >= nco_pkg::PM_W_MIN) && (nco_pkg::PM_W <= nco_pkg::PM_W_MAX) &&
        (nco_pkg::PM_W >= nco_pkg::ANGLE_W) &&
        (FM_PIPE >= 1) && (FM_PIPE <= 2) && (PM_PIPE >= 1) && (PM_PIPE <= 2);

    // register bus state
    logic                       aw_held;
    logic                       w_held;
    logic [nco_pkg::ADDR_W-1:0] aw_addr;
    logic [31:0]                w_data;
    logic [3:0]                 w_strb;
    logic                       do_wr;
    logic [31:0]                ctrl;
    logic [nco_pkg::ACC_W-1:0]  hop_tab [nco_pkg::HOP_N];
    logic [31:0]                sample_count;

    // datapath state
    nco_pkg::nco_in_t           f_data;
    logic                       f_valid;
    logic [1:0]                 f_level;
    logic [nco_pkg::ACC_W-1:0]  inc_q;
    logic [nco_pkg::FM_W-1:0]   fm_q [2];
    logic [nco_pkg::PM_W-1:0]   pm_q [2];
    logic [nco_pkg::ACC_W-1:0]  acc;
    logic [nco_pkg::ACC_W-1:0]  act_inc;
    logic [nco_pkg::ANGLE_W-1:0] ph_q;
    logic [nco_pkg::ANGLE_W-1:0] ph_d;
    nco_pkg::nco_smp_t          smp_q;
    logic [nco_pkg::FILL_W-1:0] fill;
    logic                       hop_on;
    logic [nco_pkg::HOP_AW-1:0] hop_sel;
    logic [nco_pkg::DITH_LVL_W-1:0] dith_lvl;

    function automatic logic is_hop(input logic [nco_pkg::ADDR_W-1:0] a);
        return HOP_EN && (a[7:6] == nco_pkg::HOP_PAGE) && (a[1:0] == 2'h0);
    endfunction : is_hop

    function automatic logic [nco_pkg::HOP_AW-1:0] hop_idx(
        input logic [nco_pkg::ADDR_W-1:0] a);
        return a[5:2]; // R13
    endfunction : hop_idx

    function automatic logic reg_hit(input logic [nco_pkg::ADDR_W-1:0] a);
        return (a == nco_pkg::REG_CTRL) || (a == nco_pkg::REG_STATUS) ||
               (a == nco_pkg::REG_COUNT) || (a == nco_pkg::REG_FREQ) || is_hop(a);
    endfunction : reg_hit

    function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[8*i +: 8] = wd[8*i +: 8];
            end
        end
        return r;
    endfunction : apply_strb

    // parabolic sine of a turn fraction, saturated to full scale
    function automatic logic [nco_pkg::MAG_W-1:0] sine_fn(
        input logic [nco_pkg::ANGLE_W-1:0] p);
        logic signed [nco_pkg::ANGLE_W:0]     a;
        logic signed [nco_pkg::ANGLE_W:0]     rem;
        logic signed [2*nco_pkg::ANGLE_W+1:0] prod;
        a    = signed'({p[nco_pkg::ANGLE_W-1], p});
        rem  = nco_pkg::HALF_TURN - ((a < 0) ? -a : a);
        prod = (a * rem) >>> nco_pkg::SINE_SHIFT;
        if (prod > nco_pkg::SAT_POS) begin
            prod = nco_pkg::SAT_POS;
        end
        return nco_pkg::MAG_W'(prod);
    endfunction : sine_fn

    assign hop_on   = ctrl[nco_pkg::CTRL_HOP_ON_BIT];
    assign hop_sel  = ctrl[nco_pkg::CTRL_HOP_SEL_LSB +: nco_pkg::HOP_AW];
    assign dith_lvl = ctrl[nco_pkg::CTRL_DITH_LSB +: nco_pkg::DITH_LVL_W];
    assign do_wr    = aw_held && w_held && !s_axi_bvalid;

    // write address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held       <= 1'b0;
            s_axi_awready <= 1'b0;
            aw_addr       <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held       <= 1'b1;
            s_axi_awready <= 1'b0;
            aw_addr       <= s_axi_awaddr;
        end else if (do_wr || !aw_held) begin
            aw_held       <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held       <= 1'b0;
            s_axi_wready <= 1'b0;
            w_data       <= '0;
            w_strb       <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
        end else if (do_wr || !w_held) begin
            w_held       <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= nco_pkg::RESP_OKAY;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= reg_hit(aw_addr) ? nco_pkg::RESP_OKAY : nco_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= nco_pkg::CTRL_RST;
        end else if (do_wr && (aw_addr == nco_pkg::REG_CTRL)) begin
            ctrl <= apply_strb(ctrl, w_data, w_strb) & nco_pkg::CTRL_MASK;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < nco_pkg::HOP_N; i++) begin
                hop_tab[i] <= nco_pkg::DEF_INC; // R5
            end
        end else if (do_wr && is_hop(aw_addr)) begin // R12 R16
            hop_tab[hop_idx(aw_addr)] <= apply_strb(hop_tab[hop_idx(aw_addr)], w_data, w_strb);
        end
    end

    // read channel: one word answered the cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= '0;
            s_axi_rresp   <= nco_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= reg_hit(s_axi_araddr) ? nco_pkg::RESP_OKAY : nco_pkg::RESP_SLVERR;
            s_axi_rdata   <= '0;
            if (s_axi_araddr == nco_pkg::REG_CTRL) begin
                s_axi_rdata <= ctrl;
            end else if (s_axi_araddr == nco_pkg::REG_STATUS) begin
                s_axi_rdata[nco_pkg::STAT_CFG_OK_BIT] <= CFG_OK; // R1 R2 R3 R6 R8
                s_axi_rdata[nco_pkg::STAT_RUN_BIT]    <= (fill == nco_pkg::FILL_W'(LAT - 1));
                s_axi_rdata[nco_pkg::STAT_HOP_BIT]    <= HOP_EN && hop_on;
                s_axi_rdata[nco_pkg::STAT_FIFO_LSB +: 2] <= f_level;
            end else if (s_axi_araddr == nco_pkg::REG_COUNT) begin
                s_axi_rdata <= sample_count;
            end else if (s_axi_araddr == nco_pkg::REG_FREQ) begin
                s_axi_rdata <= 32'(nco_pkg::REAL_F_OUT_HZ); // R5
            end else if (is_hop(s_axi_araddr)) begin
                s_axi_rdata <= hop_tab[hop_idx(s_axi_araddr)];
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // input stream buffer; drained only on enabled cycles
    nco_in_fifo #(
        .WIDTH ($bits(nco_pkg::nco_in_t)),
        .DEPTH (2)
    ) u_in_fifo (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .in_valid  (s_valid),
        .in_ready  (s_ready),
        .in_data   (s_data),
        .out_valid (f_valid),
        .out_ready (clken),
        .out_data  (f_data),
        .level     (f_level)
    ); // R11

    // latest stream word, modulation pipes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inc_q <= nco_pkg::DEF_INC; // R5
            fm_q  <= '{default: '0};
            pm_q  <= '{default: '0};
        end else if (clken) begin
            if (f_valid) begin
                inc_q   <= f_data.phase_inc;
                fm_q[0] <= FM_EN ? f_data.freq_mod : '0; // R6
                pm_q[0] <= PM_EN ? f_data.phase_mod : '0; // R8
            end
            fm_q[1] <= fm_q[0]; // R7
            pm_q[1] <= pm_q[0]; // R9
        end
    end

    assign act_inc = (HOP_EN && hop_on) ? hop_tab[hop_sel] : inc_q; // R15

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc  <= '0;
            ph_q <= '0;
        end else if (clken) begin
            acc  <= acc + act_inc + nco_pkg::ACC_W'(fm_q[FM_PIPE-1]); // R18 R7
            ph_q <= acc[nco_pkg::ACC_W-1 -: nco_pkg::ANGLE_W] +
                    pm_q[PM_PIPE-1][nco_pkg::PM_W-1 -: nco_pkg::ANGLE_W]; // R18 R9
        end
    end

    generate
        if (DITHER_EN) begin : g_dither
            logic [nco_pkg::LFSR_W-1:0]  lfsr;
            logic [nco_pkg::ANGLE_W-1:0] d1;
            logic [nco_pkg::ANGLE_W-1:0] d2;
            logic [nco_pkg::DITH_LVL_MAX-1:0] noise;
            // level 0 injects nothing, the top level the widest noise
            assign noise = lfsr[nco_pkg::DITH_LVL_MAX-1:0] >>
                           (nco_pkg::DITH_LVL_W'(nco_pkg::DITH_LVL_MAX) - dith_lvl); // R4
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    lfsr <= nco_pkg::LFSR_SEED;
                    d1   <= '0;
                    d2   <= '0;
                end else if (clken) begin
                    lfsr <= lfsr[0] ? ((lfsr >> 1) ^ nco_pkg::LFSR_TAPS) : (lfsr >> 1);
                    d1   <= ph_q + nco_pkg::ANGLE_W'(noise); // R4 R17
                    d2   <= d1; // R17
                end
            end
            assign ph_d = d2;
        end else begin : g_no_dither
            assign ph_d = ph_q; // R17
        end
    endgenerate

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            smp_q  <= '0;
            m_data <= '0;
        end else if (clken) begin
            smp_q.sin_v <= sine_fn(ph_d);
            smp_q.cos_v <= sine_fn(ph_d + nco_pkg::QUARTER_TURN);
            m_data      <= smp_q; // R11
        end
    end

    // start latency count; sink ready is never looked at
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fill    <= '0;
            m_valid <= 1'b0;
        end else begin
            if (clken && (fill != nco_pkg::FILL_W'(LAT - 1))) begin
                fill <= fill + nco_pkg::FILL_W'(1);
            end
            m_valid <= clken && (fill == nco_pkg::FILL_W'(LAT - 1)); // R14 R10
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sample_count <= '0;
        end else if (m_valid) begin
            sample_count <= sample_count + 32'h0000_0001;
        end
    end
endmodule : nco_core

/* bench/nco_core_monitor.sv */
// nco_core_monitor: port-level timing checks of the oscillator.
// assumes the bind at the foot attaches it to every nco_core.
`timescale 1ns/1ps
module nco_core_monitor (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clken,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_valid,
    input wire logic        s_ready,
    input wire logic        m_valid,
    input wire nco_pkg::nco_smp_t m_data
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_both_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_two_push;
        (s_valid && s_ready && !clken) [*2];
    endsequence
    // address channel closes for at least one cycle, then reopens as soon as the data is taken
    sequence s_read_turn;
        !s_axi_arready ##1 (s_axi_arready != s_axi_rvalid);
    endsequence
    chk_idle_quiet: assert property (!clken |=> !m_valid && $stable(m_data))
        else $error("sample moved while clock enable low");
    chk_run_steady: assert property (m_valid && clken |=> m_valid)
        else $error("sample stream stalled");
    chk_fill_bound: assert property (clken [*8] |=> m_valid)
        else $error("start latency too long");
    chk_write_resp: assert property (s_both_take |=> ##1 s_axi_bvalid)
        else $error("write response late");
    chk_write_close: assert property (s_both_take |=> !s_axi_awready && !s_axi_wready)
        else $error("write channels stayed open");
    chk_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response not dropped");
    chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_read_close: assert property (s_axi_arvalid && s_axi_arready |=> s_read_turn)
        else $error("read address reopened early");
    chk_buffer_full: assert property (s_two_push |=> !s_ready)
        else $error("buffer full but still ready");
endmodule : nco_core_monitor

bind nco_core nco_core_monitor u_mon (.aclk, .aresetn, .clken, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_valid, .s_ready, .m_valid, .m_data);

/* bench/nco_sink_model.sv */
// nco_sink_model: downstream consumer that counts every sample.
// assumes the source ignores m_ready, so it toggles it freely.
`timescale 1ns/1ps
module nco_sink_model (
    input wire logic    aclk,
    input wire logic    aresetn,
    input wire logic    m_valid,
    output logic        m_ready,
    output int unsigned seen
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            m_ready <= 1'b0;
            seen    <= 0;
        end else begin
            m_ready <= !m_ready;
            if (m_valid) seen <= seen + 1;
        end
    end
endmodule : nco_sink_model

/* bench/nco_core_test.sv */
// nco_core_test: register and stream tests of the oscillator.
// assumes nco_core, nco_sink_model and the monitor bind are compiled.
`timescale 1ns/1ps
module nco_core_test;
    logic aclk, aresetn, clken, m_ready, m_valid, s_valid, s_ready;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [nco_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    nco_pkg::nco_in_t  s_data;
    nco_pkg::nco_smp_t m_data;
    int unsigned seen, errors, checked;

    nco_core u_dut (.aclk, .aresetn, .clken, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .s_valid, .s_ready, .s_data, .m_valid,
        .m_ready, .m_data);
    nco_sink_model u_sink (.aclk, .aresetn, .m_valid, .m_ready, .seen);

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic conclude;
        if (errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // one bus transfer; for a read d is the expected data
    task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] r);
        int n;
        n = 0;
        s_axi_awaddr  <= a;
        s_axi_araddr  <= a;
        s_axi_wdata   <= d;
        s_axi_awvalid <= w;
        s_axi_wvalid  <= w;
        s_axi_arvalid <= !w;
        s_axi_bready  <= w;
        s_axi_rready  <= !w;
        do begin
            @(posedge aclk);
            n++;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1 && s_axi_rvalid !== 1'b1 && n < 64);
        if (n >= 64) begin
            errors++;
            conclude();
        end
        check("resp", w ? s_axi_bresp : s_axi_rresp, r);
        if (!w) check("rdata", s_axi_rdata, d);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi

    // leaves s_valid high so that words can follow back to back
    task automatic push(input nco_pkg::nco_in_t word);
        int n;
        n = 0;
        s_data  <= word;
        s_valid <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
        end while (s_ready !== 1'b1 && n < 64);
        if (n >= 64) begin
            errors++;
            conclude();
        end
    endtask : push

    initial begin
        aresetn = 1'b0;
        clken = 1'b0;
        s_valid = 1'b0;
        s_data = '0;
        s_axi_wstrb = 4'hF;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_bready, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        errors = 0;
        checked = 0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi(0, nco_pkg::REG_CTRL, nco_pkg::CTRL_RST, nco_pkg::RESP_OKAY);
        axi(0, nco_pkg::REG_FREQ, 32'(nco_pkg::REAL_F_OUT_HZ), nco_pkg::RESP_OKAY);
        axi(0, 8'h40, 32'(nco_pkg::DEF_INC), nco_pkg::RESP_OKAY);
        axi(0, 8'h20, 32'h0000_0000, nco_pkg::RESP_SLVERR);
        axi(1, 8'h80, 32'h1234_5678, nco_pkg::RESP_SLVERR);
        axi(1, nco_pkg::REG_CTRL, 32'hFFFF_FFFF, nco_pkg::RESP_OKAY);
        axi(0, nco_pkg::REG_CTRL, nco_pkg::CTRL_MASK, nco_pkg::RESP_OKAY);
        for (int i = 0; i < 16; i++)
            axi(1, 8'h40 + 8'(4 * i), 32'h1000_0000 + 32'(i), nco_pkg::RESP_OKAY);
        for (int i = 0; i < 16; i++)
            axi(0, 8'h40 + 8'(4 * i), 32'h1000_0000 + 32'(i), nco_pkg::RESP_OKAY);
        push('{16'h4000, 32'h0000_0100, 32'h0100_0000});
        push('{16'h0000, 32'h0000_0000, 32'h0200_0000});
        s_valid <= 1'b0;
        @(posedge aclk);
        check("s_ready", 32'(s_ready), 32'h0000_0000);
        clken <= 1'b1;
        repeat (40) @(posedge aclk);
        clken <= 1'b0;
        repeat (2) @(posedge aclk);
        check("s_ready", 32'(s_ready), 32'h0000_0001);
        // 40 enabled cycles give one sample per cycle once the start latency is filled
        check("seen", seen, 32'(41 - nco_pkg::BASE_LAT - nco_pkg::DITH_LAT_ON));
        axi(0, nco_pkg::REG_COUNT, seen, nco_pkg::RESP_OKAY);
        axi(0, nco_pkg::REG_STATUS, 32'h0000_0007, nco_pkg::RESP_OKAY);
        // mid-run reset, then a frozen phase from a zero hop increment
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        axi(1, 8'h40, 32'h0000_0000, nco_pkg::RESP_OKAY);
        axi(1, nco_pkg::REG_CTRL, 32'h0000_0001, nco_pkg::RESP_OKAY);
        push('{16'h4000, 32'h0000_0000, 32'h0000_0000});
        s_valid <= 1'b0;
        clken   <= 1'b1;
        repeat (4) @(posedge aclk);
        check("m_data", m_data, 32'h7FFF_0000);
        repeat (8) @(posedge aclk);
        check("m_data", m_data, 32'h0000_7FFF);
        conclude();
    end
endmodule : nco_core_test
